/* logic/srst_pkg.sv */
package srst_pkg;
  // ****************************************
  // status register layout
  // ****************************************
  localparam int STAT_W = 8;
  localparam int BIT_PPEN = 7;
  localparam int BIT_BPH = 3;
  localparam int BIT_BPL = 2;
  localparam int BIT_WLF = 1;
  localparam int BIT_RDY = 0;
  localparam logic [2:0] NV_DELIVERED = 3'h0;
  localparam logic [7:0] ARRAY_DELIVERED = 8'hFF;
  // ****************************************
  // opcodes, bit 3 is a don't care
  // ****************************************
  localparam logic [7:0] OPC_MASK = 8'hF7;
  localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
  localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int POWERUP_WAIT_TIME_US = 100;
  localparam int POWERUP_WAIT_CYC = POWERUP_WAIT_TIME_US * CLK_MHZ;
  typedef enum logic [2:0] {
    SRST_POR = 3'h1,
    SRST_IDLE = 3'h2,
    SRST_SEL = 3'h4
  } srst_state_t;
endpackage

/* logic/srst_sync.sv */
`timescale 1ns/1ns
module srst_sync (
  input wire logic clk, // clock
  input wire logic reset, // sync reset
  input wire logic d, // async level
  input wire logic init, // reset value
  output logic q // synchronised level
);
  logic s1_q;
  logic s2_q;
  logic s1_d;
  logic s2_d;
  always_comb begin
    s1_d = d;
    s2_d = s1_q;
  end
  // init is a tie-off, so each pin settles to the level its edge logic needs
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= init;
      s2_q <= init;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end
  assign q = s2_q;
endmodule

/* logic/srst_top.sv */
`timescale 1ns/1ns
module srst_top (
  input wire logic clk, // 250 MHz clock
  input wire logic reset, // power-on reset, high
  input wire logic cs_n, // chip select pin, low active
  input wire logic sck, // serial clock pin
  input wire logic si, // serial data in pin
  input wire logic hold_n, // hold pin, low active
  input wire logic [2:0] nv_bits, // stored pin enable and protect
  output logic so, // serial data out
  output logic so_oe, // serial output enable
  output logic [7:0] status, // status register image
  output logic selected, // device selected
  output logic in_hold, // hold condition active
  output logic standby, // standby mode
  output logic [7:0] opcode, // last complete opcode
  output logic opcode_valid // pulse on new opcode
);
  import srst_pkg::*;
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic cs_s;
  logic sck_s;
  logic si_s;
  logic hold_s;
  // select resets low: a select held low through power-up then shows no
  // falling edge, and only a real high-to-low change selects
  srst_sync u_cs (.clk(clk), .reset(reset), .d(cs_n), .init(1'b0),
    .q(cs_s));
  srst_sync u_sck (.clk(clk), .reset(reset), .d(sck), .init(1'b1),
    .q(sck_s));
  srst_sync u_si (.clk(clk), .reset(reset), .d(si), .init(1'b1),
    .q(si_s));
  srst_sync u_hd (.clk(clk), .reset(reset), .d(hold_n), .init(1'b1),
    .q(hold_s));
  // ****************************************
  // interface state
  // ****************************************
  srst_state_t st_q, st_d;
  logic cs_prev_q, cs_prev_d;
  logic sck_prev_q, sck_prev_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic wlf_q, wlf_d;
  logic [7:0] opc_q, opc_d;
  logic opv_q, opv_d;
  logic hold_q, hold_d;
  logic [2:0] nv_q, nv_d;
  logic cs_fall;
  logic sck_rise;
  logic [7:0] byte_in;
  always_comb begin
    cs_fall = cs_prev_q & ~cs_s;
    sck_rise = ~sck_prev_q & sck_s;
    byte_in = {sh_q[6:0], si_s};
    st_d = st_q;
    cs_prev_d = cs_s;
    sck_prev_d = sck_s;
    cnt_d = cnt_q;
    sh_d = sh_q;
    wlf_d = wlf_q;
    opc_d = opc_q;
    opv_d = 1'b0;
    hold_d = hold_q;
    nv_d = nv_q;
    unique case (st_q)
      SRST_POR: begin
        // nonvolatile bits are captured once, after reset release
        nv_d = nv_bits;
        st_d = SRST_IDLE;
      end
      SRST_IDLE: begin
        cnt_d = 3'h0;
        hold_d = 1'b0;
        // a select already low at power-up has no edge here
        if (cs_fall) begin
          st_d = SRST_SEL;
        end
      end
      SRST_SEL: begin
        if (cs_s) begin
          // partial byte dropped, next selection collects an opcode
          st_d = SRST_IDLE;
          cnt_d = 3'h0;
          // leaving while held aborts the command, so the latch drops too
          if (hold_q) begin
            wlf_d = 1'b0;
          end
          hold_d = 1'b0;
        end else begin
          if (!sck_s) begin
            hold_d = ~hold_s;
          end
          if (sck_rise && !hold_q) begin
            sh_d = byte_in;
            cnt_d = cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              opc_d = byte_in;
              opv_d = 1'b1;
              if ((byte_in & OPC_MASK) == SET_WRITE_LATCH_CMD) begin
                wlf_d = 1'b1;
              end else if ((byte_in & OPC_MASK) ==
                           CLEAR_WRITE_LATCH_CMD) begin
                wlf_d = 1'b0;
              end
            end
          end
        end
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= SRST_POR;
      cs_prev_q <= 1'b0;
      sck_prev_q <= 1'b1;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      wlf_q <= 1'b0;
      opc_q <= 8'h00;
      opv_q <= 1'b0;
      hold_q <= 1'b0;
      nv_q <= NV_DELIVERED;
    end else begin
      st_q <= st_d;
      cs_prev_q <= cs_prev_d;
      sck_prev_q <= sck_prev_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      wlf_q <= wlf_d;
      opc_q <= opc_d;
      opv_q <= opv_d;
      hold_q <= hold_d;
      nv_q <= nv_d;
    end
  end
  // ****************************************
  // outputs
  // ****************************************
  always_comb begin
    status = 8'h00;
    status[BIT_PPEN] = nv_q[2];
    status[BIT_BPH] = nv_q[1];
    status[BIT_BPL] = nv_q[0];
    status[BIT_WLF] = wlf_q;
    status[BIT_RDY] = 1'b0;
  end
  // no read path here, so the output never drives
  assign so = 1'b0;
  assign so_oe = 1'b0;
  assign selected = (st_q == SRST_SEL);
  assign in_hold = hold_q;
  assign standby = (st_q == SRST_IDLE);
  assign opcode = opc_q;
  assign opcode_valid = opv_q;
  // ****************************************
  // checks
  // ****************************************
  AST_POR_IGNORE: assert property (@(posedge clk)
    disable iff (reset) $past(reset) |-> !selected && !opcode_valid)
    else $error("instruction taken during reset");
  AST_SEL_FROM_STANDBY: assert property (@(posedge clk)
    disable iff (reset) $rose(selected) |-> $past(standby))
    else $error("selection not taken from standby");
  AST_STANDBY_AFTER_POR: assert property (@(posedge clk)
    disable iff (reset) st_q == SRST_POR |=> standby)
    else $error("no standby after power-on reset");
  AST_WLF_CLEAR: assert property (@(posedge clk)
    $fell(reset) |-> !status[BIT_WLF])
    else $error("write latch not cleared at power-up");
  AST_RDY_ZERO: assert property (@(posedge clk)
    disable iff (reset) !status[BIT_RDY])
    else $error("ready busy not zero");
  AST_UNUSED_ZERO: assert property (@(posedge clk)
    disable iff (reset) status[6:4] == 3'h0)
    else $error("unused status bits not zero");
  AST_SO_OFF: assert property (@(posedge clk)
    disable iff (reset) !selected |-> !so_oe)
    else $error("output driven while deselected");
  AST_IDLE_NO_OPCODE: assert property (@(posedge clk)
    disable iff (reset) !selected |=> !opcode_valid)
    else $error("opcode taken while deselected");
  AST_SEL_EDGE: assert property (@(posedge clk)
    disable iff (reset) $rose(selected) |-> $past(cs_s, 2) && !$past(cs_s))
    else $error("selection without falling edge");
  AST_DESEL_IDLE: assert property (@(posedge clk)
    disable iff (reset)
    selected && cs_s |=> !selected && cnt_q == 3'h0 ##1 cnt_q == 3'h0)
    else $error("deselect did not return to idle");
  AST_DESEL_CAUSE: assert property (@(posedge clk)
    disable iff (reset) $fell(selected) |-> $past(cs_s))
    else $error("deselected while select held low");
  AST_IDLE_COUNT: assert property (@(posedge clk)
    disable iff (reset) standby |-> cnt_q == 3'h0)
    else $error("partial byte kept in standby");
  AST_HOLD_DESEL: assert property (@(posedge clk)
    disable iff (reset) selected && cs_s && in_hold |=> !status[BIT_WLF])
    else $error("deselect in hold kept write latch");
  AST_SET_LATCH: assert property (@(posedge clk)
    disable iff (reset)
    opcode_valid && (opcode & OPC_MASK) == SET_WRITE_LATCH_CMD
    |-> status[BIT_WLF])
    else $error("set opcode did not set latch");
  AST_CLR_LATCH: assert property (@(posedge clk)
    disable iff (reset)
    opcode_valid && (opcode & OPC_MASK) == CLEAR_WRITE_LATCH_CMD
    |-> !status[BIT_WLF])
    else $error("clear opcode did not clear latch");
  AST_OPV_PULSE: assert property (@(posedge clk)
    disable iff (reset) opcode_valid |=> !opcode_valid)
    else $error("opcode strobe longer than one cycle");
  AST_OPC_STABLE: assert property (@(posedge clk)
    disable iff (reset) !opcode_valid |-> $stable(opcode))
    else $error("opcode changed without strobe");
  AST_NV_HOLD: assert property (@(posedge clk)
    disable iff (reset)
    st_q != SRST_POR && $past(st_q) != SRST_POR |-> $stable(status[7:2]))
    else $error("protect bits changed");
  AST_NV_CAPTURE: assert property (@(posedge clk)
    disable iff (reset) st_q == SRST_POR |=>
    status[BIT_PPEN] == $past(nv_bits[2]) &&
    status[BIT_BPH] == $past(nv_bits[1]) &&
    status[BIT_BPL] == $past(nv_bits[0]))
    else $error("stored protect bits not loaded");
  AST_IDLE_HOLD_OFF: assert property (@(posedge clk)
    disable iff (reset) standby |-> !in_hold)
    else $error("hold kept while in standby");
  AST_RESET_STANDBY: assert property (@(posedge clk)
    $fell(reset) ##1 1'b1 |-> !in_hold && !selected && standby)
    else $error("power-up not in standby");
endmodule

/* tb/srst_master.sv */
`timescale 1ns/1ns
module srst_master (
  input wire logic clk, // bench clock
  output logic cs_n, // chip select, low active
  output logic sck, // link clock, idles low
  output logic si // serial data to device
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic set_cs(input logic v);
    cs_n = v;
  endtask
  // 8 clk per half period gives the 64 ns link clock
  task automatic frame(input logic [7:0] v, input int nbits,
                       input logic sel);
    tick(1);
    if (sel) begin
      cs_n = 1'b0;
    end
    tick(8);
    for (int i = 7; i > 7 - nbits; i--) begin
      si = v[i];
      tick(8);
      sck = 1'b1;
      tick(8);
      sck = 1'b0;
    end
    tick(8);
    cs_n = 1'b1;
    si = ~si; // released line must not keep a stale level
    tick(8);
  endtask
  // select pulse with no link clock
  task automatic toggle();
    cs_n = 1'b0;
    tick(8);
    cs_n = 1'b1;
    tick(8);
  endtask
endmodule

/* tb/srst_top_bench.sv */
`timescale 1ns/1ns
module srst_top_bench;
  import srst_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hold_n = 1'b1;
  logic [2:0] nv_bits = 3'h0;
  logic cs_n, sck, si, so, so_oe, selected, in_hold, standby, opcode_valid;
  logic [7:0] status, opcode;
  logic [7:0] cmds [4] = '{8'h06, 8'h04, 8'h0E, 8'h0C};
  int num_errors = 0;
  int num_checks = 0;
  int n_op = 0;
  always #2 clk = ~clk;
  always @(posedge clk) if (opcode_valid === 1'b1) n_op <= n_op + 1;
  srst_master i_srst_master (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si));
  srst_top i_srst_top (.clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck),
    .si(si), .hold_n(hold_n), .nv_bits(nv_bits), .so(so), .so_oe(so_oe),
    .status(status), .selected(selected), .in_hold(in_hold),
    .standby(standby), .opcode(opcode), .opcode_valid(opcode_valid));
  task automatic check(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // idle pins: output off, not selected, no hold, in standby
  task automatic check_idle();
    check("pins", 8'h01, {4'h0, so_oe, selected, in_hold, standby});
  endtask
  task automatic power_up(input logic [2:0] nv);
    @(posedge clk);
    #1 reset = 1'b1;
    nv_bits = nv;
    repeat (6) @(posedge clk);
    #1 reset = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("status", {nv[2], 3'h0, nv[1:0], 2'h0}, status);
    check_idle();
    repeat (POWERUP_WAIT_CYC) @(posedge clk);
  endtask
  task automatic t_held_low();
    int n0;
    i_srst_master.tick(1);
    i_srst_master.set_cs(1'b0);
    power_up(3'h0);
    n0 = n_op;
    i_srst_master.frame(8'h06, 8, 1'b0);
    check("ops", n0[7:0], n_op[7:0]);
    check("latch", 8'h00, {7'h0, status[BIT_WLF]});
  endtask
  task automatic t_latch();
    for (int i = 0; i < 4; i++) begin
      i_srst_master.frame(cmds[i], 8, 1'b1);
      check("opcode", cmds[i], opcode);
      check("latch", {7'h0, cmds[i][1]}, {7'h0, status[BIT_WLF]});
      check_idle();
    end
  endtask
  task automatic t_abort();
    int n0;
    n0 = n_op;
    i_srst_master.frame(8'hF0, 4, 1'b1);
    i_srst_master.toggle();
    i_srst_master.frame(8'h06, 8, 1'b1);
    check("ops", n0[7:0] + 8'h01, n_op[7:0]);
    check("opcode", 8'h06, opcode);
  endtask
  task automatic t_deselected();
    int n0;
    n0 = n_op;
    i_srst_master.frame(8'h04, 8, 1'b0);
    check("ops", n0[7:0], n_op[7:0]);
    check("latch", 8'h01, {7'h0, status[BIT_WLF]});
  endtask
  // select, enter hold, then deselect while still held
  task automatic t_hold();
    i_srst_master.set_cs(1'b0);
    i_srst_master.tick(8);
    hold_n = 1'b0;
    i_srst_master.tick(8);
    check("hold", 8'h01, {7'h0, in_hold});
    i_srst_master.set_cs(1'b1);
    i_srst_master.tick(8);
    check("latch", 8'h00, {7'h0, status[BIT_WLF]});
    check_idle();
    hold_n = 1'b1;
  endtask
  task automatic finish_test();
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    t_held_low();
    t_latch();
    t_abort();
    t_deselected();
    t_hold();
    power_up(3'h5);
    power_up(3'h2);
    finish_test();
  end
endmodule
